//--- src/pcg_clock_gate.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`include "pcg_consts.svh"

module pcg_clock_gate
  import pcg_pkg::*;
#(
  parameter int NUM_REGS = 12
)
(
  // Clock and resets.
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  // Write protection override from the CPU.
  input wire logic i_write_protect_override,
  // Avalon-MM slave.
  input wire pcg_avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Clocks out.
  output logic o_system_clock_out,
  output logic o_i2c_clock,
  output logic [8:0] o_gated_clock,
  output logic o_low_speed_periph_clock,
  output logic o_high_speed_periph_clock,
  // Enable levels.
  output logic o_timebase_sync,
  output logic [15:0] o_gate1_en,
  output logic [15:0] o_gate3_en
);

  localparam int SLOT_GATE0 = 3;
  localparam int SLOT_GATE1 = 4;
  localparam int SLOT_GATE3 = 6;
  localparam int SLOT_PLL_CTRL = 7;
  localparam int SLOT_HS = 1;
  localparam int SLOT_LS = 2;
  localparam int SLOT_WD_COUNTER = 9;
  localparam int DLY = `PCG_GATE_DELAY_CYC;

  localparam logic [14:0] SLOT_IDX [NUM_REGS] = '{
    `PCG_IDX_PLL_STATUS, `PCG_IDX_HS_PRESC, `PCG_IDX_LS_PRESC, `PCG_IDX_GATE0,
    `PCG_IDX_GATE1, `PCG_IDX_LOW_POWER, `PCG_IDX_GATE3, `PCG_IDX_PLL_CTRL,
    `PCG_IDX_SYS_STATUS, `PCG_IDX_WD_COUNTER, `PCG_IDX_WD_KEY, `PCG_IDX_WD_CTRL
  };
  localparam logic [15:0] SLOT_MASK [NUM_REGS] = '{
    `PCG_WMASK_ALL, `PCG_WMASK_ALL, `PCG_WMASK_ALL, `PCG_WMASK_GATE0,
    `PCG_WMASK_ALL, `PCG_WMASK_ALL, `PCG_WMASK_ALL, `PCG_WMASK_ALL,
    `PCG_WMASK_ALL, `PCG_WMASK_NONE, `PCG_WMASK_ALL, `PCG_WMASK_ALL
  };
  localparam bit SLOT_PLL [NUM_REGS] = '{
    1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0
  };

  // Divided clock gates: bit in gate 0 and source (0 half, 1 low, 2 high).
  localparam int NUM_GATES = 9;
  localparam int GATE_BIT [NUM_GATES] = '{
    `PCG_BIT_CAN_B, `PCG_BIT_CAN_A, `PCG_BIT_SYNC_B, `PCG_BIT_SYNC_A,
    `PCG_BIT_UART_B, `PCG_BIT_UART_A, `PCG_BIT_SPI, `PCG_BIT_UART_C,
    `PCG_BIT_CONVERTER
  };
  localparam int GATE_SRC [NUM_GATES] = '{0, 0, 1, 1, 1, 1, 1, 1, 2};

  function automatic logic [3:0] slot_of(input logic [14:0] idx);
    logic [3:0] s_found;
    s_found = 4'hF;
    for (int s = 0; s < NUM_REGS; s++)
    begin
      if (idx == SLOT_IDX[s])
      begin
        s_found = 4'(s);
      end
    end
    return s_found;
  endfunction

  pcg_bus_e bus_state_ff;
  pcg_word_t regs_ff [NUM_REGS];
  logic [47:0] gate_pipe_ff [DLY];
  logic [2:0] src_ff;
  logic [2:0] nxt_src;
  logic [`PCG_PRESC_W-1:0] div_cnt_ff [2];
  logic [3:0] hit_slot;
  logic bus_commit_wr;
  logic [15:0] be_mask;
  logic [15:0] gate0_eff;
  logic i2c_en_ff;

  assign hit_slot = (i_avs.address[1:0] == 2'b00) ? slot_of(i_avs.address[16:2]) : 4'hF;
  assign bus_commit_wr = (bus_state_ff == PCG_BUS_ANSWER) && i_avs.write;
  assign be_mask = {{8{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};
  assign gate0_eff = gate_pipe_ff[DLY-1][15:0];

  // Each request is held one cycle, then answered with waitrequest low.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bus_state_ff <= PCG_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (bus_state_ff)
        PCG_BUS_IDLE:
        begin
          if (i_avs.read || i_avs.write)
          begin
            bus_state_ff <= PCG_BUS_ANSWER;
            o_avs_waitrequest <= 1'b0;
          end
        end
        PCG_BUS_ANSWER:
        begin
          bus_state_ff <= PCG_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state_ff <= PCG_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data is loaded together with the answer; unmapped reads return zero.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_avs_readdata <= 32'h0000_0000;
    end
    else if (bus_state_ff == PCG_BUS_IDLE && i_avs.read)
    begin
      o_avs_readdata <= (hit_slot == 4'hF) ? 32'h0000_0000 : {16'h0000, regs_ff[hit_slot]};
    end
  end

  // The register file. PLL slots answer only to the hard reset.
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    logic wr_ok;
    logic [15:0] wmask;
    assign wr_ok = bus_commit_wr && (hit_slot == 4'(g)) && i_write_protect_override;
    assign wmask = be_mask & SLOT_MASK[g];

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
      begin
        regs_ff[g] <= `PCG_RST_WORD;
      end
      else if (i_soft_rst && !SLOT_PLL[g])
      begin
        regs_ff[g] <= `PCG_RST_WORD;
      end
      else if (wr_ok && !i_soft_rst)
      begin
        regs_ff[g] <= (regs_ff[g] & ~wmask) | (i_avs.writedata[15:0] & wmask);
      end
    end
  end

  // Gating state trails the registers by a fixed pipeline so that a new
  // setting never reaches a peripheral before software may rely on it.
  for (genvar st = 0; st < DLY; st++)
  begin : g_pipe
    if (st == 0)
    begin : g_first
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          gate_pipe_ff[st] <= 48'h0000_0000_0000;
        end
        else
        begin
          gate_pipe_ff[st] <= {regs_ff[SLOT_GATE3], regs_ff[SLOT_GATE1],
            regs_ff[SLOT_GATE0]};
        end
      end
    end
    else
    begin : g_next
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          gate_pipe_ff[st] <= 48'h0000_0000_0000;
        end
        else
        begin
          gate_pipe_ff[st] <= gate_pipe_ff[st-1];
        end
      end
    end
  end

  // Half-rate source toggles every cycle.
  assign nxt_src[0] = ~src_ff[0];

  // Low and high speed sources: period is twice (ratio + 1) cycles.
  for (genvar d = 0; d < 2; d++)
  begin : g_div
    logic [`PCG_PRESC_W-1:0] ratio;
    logic wrap;
    assign ratio = regs_ff[d == 0 ? SLOT_LS : SLOT_HS][`PCG_PRESC_W-1:0];
    assign wrap = (div_cnt_ff[d] >= ratio);
    assign nxt_src[d+1] = wrap ? ~src_ff[d+1] : src_ff[d+1];

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
      begin
        div_cnt_ff[d] <= '0;
      end
      else
      begin
        div_cnt_ff[d] <= wrap ? '0 : div_cnt_ff[d] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      src_ff <= 3'h0;
    end
    else
    begin
      src_ff <= nxt_src;
    end
  end

  // A gated clock may only rise with its source and, once high, follows
  // the source down, so every pulse it gives is a whole one.
  for (genvar k = 0; k < NUM_GATES; k++)
  begin : g_gate
    logic en;
    logic s_now;
    logic s_nxt;
    assign en = gate0_eff[GATE_BIT[k]];
    assign s_now = src_ff[GATE_SRC[k]];
    assign s_nxt = nxt_src[GATE_SRC[k]];

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
      begin
        o_gated_clock[k] <= 1'b0;
      end
      else
      begin
        o_gated_clock[k] <= s_nxt & (o_gated_clock[k] | (en & ~s_now));
      end
    end
  end

  // The enable for the full-rate gate changes on the falling edge, while
  // the clock is low, as a latch-based gate would.
  always_ff @(negedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      i2c_en_ff <= 1'b0;
    end
    else
    begin
      i2c_en_ff <= gate0_eff[`PCG_BIT_I2C];
    end
  end

  assign o_i2c_clock = i_mclk & i2c_en_ff;
  assign o_system_clock_out = i_mclk;
  assign o_low_speed_periph_clock = src_ff[1];
  assign o_high_speed_periph_clock = src_ff[2];
  assign o_timebase_sync = gate0_eff[`PCG_BIT_TB_SYNC];
  assign o_gate1_en = gate_pipe_ff[DLY-1][31:16];
  assign o_gate3_en = gate_pipe_ff[DLY-1][47:32];

  a_gate_latency: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $changed(regs_ff[SLOT_GATE0]) |-> ##1 (gate0_eff != regs_ff[SLOT_GATE0] ||
      $past(gate0_eff) == regs_ff[SLOT_GATE0]) ##1 (gate0_eff == $past(regs_ff[SLOT_GATE0], 2)))
    else $error("gate 0 change did not take effect two cycles after the write");

  a_protect_blocks: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (bus_commit_wr && !i_write_protect_override && !i_soft_rst) |=>
      $stable(regs_ff[SLOT_GATE0]) && $stable(regs_ff[SLOT_GATE1]) &&
      $stable(regs_ff[SLOT_PLL_CTRL]))
    else $error("register changed by a write while protected");

  a_pll_survives: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_soft_rst |=> $stable(regs_ff[SLOT_PLL_CTRL]))
    else $error("pll control changed on a soft reset");

  a_soft_clears: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_soft_rst |=> (regs_ff[SLOT_GATE0] == 16'h0000) && (regs_ff[SLOT_GATE1] == 16'h0000))
    else $error("gate registers not cleared by a soft reset");

  a_reserved_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (regs_ff[SLOT_GATE0] & ~`PCG_WMASK_GATE0) == 16'h0000)
    else $error("reserved gate 0 bit is set");

  a_answer_time: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ((i_avs.read || i_avs.write) && bus_state_ff == PCG_BUS_IDLE) |=>
      !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not given one cycle after the request");

  a_read_gate0: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_avs.read && bus_state_ff == PCG_BUS_IDLE && hit_slot == 4'(SLOT_GATE0)) |=>
      o_avs_readdata == {16'h0000, $past(regs_ff[SLOT_GATE0])})
    else $error("gate 0 read data wrong");

  a_can_b_runs: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (gate0_eff[`PCG_BIT_CAN_B] && $past(gate0_eff[`PCG_BIT_CAN_B]) &&
      $past(gate0_eff[`PCG_BIT_CAN_B], 2) && $past(gate0_eff[`PCG_BIT_CAN_B], 3)) |->
      o_gated_clock[0] != $past(o_gated_clock[0]))
    else $error("enabled CAN B clock is not at half rate");

  a_can_a_stops: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!gate0_eff[`PCG_BIT_CAN_A] && !$past(gate0_eff[`PCG_BIT_CAN_A]) &&
      !$past(gate0_eff[`PCG_BIT_CAN_A], 2)) |-> !o_gated_clock[1])
    else $error("disabled CAN A clock still running");

  a_whole_pulse: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $rose(o_gated_clock[2]) |-> $rose(src_ff[1]))
    else $error("gated clock rose away from its source edge");

  // The two cycles after a hard reset are skipped because the history there is stale.
  a_gate_delay: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_rst, 2)) |->
      ({o_gate3_en, o_gate1_en, gate0_eff} == {$past(regs_ff[SLOT_GATE3], 2),
      $past(regs_ff[SLOT_GATE1], 2), $past(regs_ff[SLOT_GATE0], 2)}))
    else $error("gating state does not trail its register by two cycles");

  a_can_b_stops: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!gate0_eff[`PCG_BIT_CAN_B] && !$past(gate0_eff[`PCG_BIT_CAN_B]) &&
      !$past(gate0_eff[`PCG_BIT_CAN_B], 2)) |-> !o_gated_clock[0])
    else $error("disabled CAN B clock still running");

  a_can_a_runs: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (gate0_eff[`PCG_BIT_CAN_A] && $past(gate0_eff[`PCG_BIT_CAN_A]) &&
      $past(gate0_eff[`PCG_BIT_CAN_A], 2) && $past(gate0_eff[`PCG_BIT_CAN_A], 3)) |->
      o_gated_clock[1] != $past(o_gated_clock[1]))
    else $error("enabled CAN A clock is not at half rate");

  a_counter_fixed: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    regs_ff[SLOT_WD_COUNTER] == `PCG_RST_WORD)
    else $error("read-only watchdog counter slot was written");

endmodule // pcg_clock_gate

//--- src/pcg_consts.svh
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// Register word indices; the byte address is four times the index.
`define PCG_IDX_PLL_STATUS 15'h7011
`define PCG_IDX_HS_PRESC 15'h701A
`define PCG_IDX_LS_PRESC 15'h701B
`define PCG_IDX_GATE0 15'h701C
`define PCG_IDX_GATE1 15'h701D
`define PCG_IDX_LOW_POWER 15'h701E
`define PCG_IDX_GATE3 15'h7020
`define PCG_IDX_PLL_CTRL 15'h7021
`define PCG_IDX_SYS_STATUS 15'h7022
`define PCG_IDX_WD_COUNTER 15'h7023
`define PCG_IDX_WD_KEY 15'h7025
`define PCG_IDX_WD_CTRL 15'h7029

// Writable bits per register.
`define PCG_WMASK_ALL 16'hFFFF
`define PCG_WMASK_NONE 16'h0000
`define PCG_WMASK_GATE0 16'hFD3C

// Reset values.
`define PCG_RST_WORD 16'h0000

// Gate 0 field positions.
`define PCG_BIT_CAN_B 15
`define PCG_BIT_CAN_A 14
`define PCG_BIT_SYNC_B 13
`define PCG_BIT_SYNC_A 12
`define PCG_BIT_UART_B 11
`define PCG_BIT_UART_A 10
`define PCG_BIT_SPI 8
`define PCG_BIT_UART_C 5
`define PCG_BIT_I2C 4
`define PCG_BIT_CONVERTER 3
`define PCG_BIT_TB_SYNC 2

// Prescaler ratio field.
`define PCG_PRESC_W 3

// Gating latency in system clock cycles.
`define PCG_GATE_DELAY_CYC 2

`endif

//--- src/pcg_pkg.sv
package pcg_pkg;

  typedef logic [15:0] pcg_word_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [16:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pcg_avs_req_s;

  typedef enum logic [1:0] {
    PCG_BUS_IDLE = 2'b00,
    PCG_BUS_ANSWER = 2'b01
  } pcg_bus_e;

endpackage

//--- tb/pcg_periph_model.sv
module pcg_periph_model (
  // Clocks as the peripheral modules receive them.
  input wire logic [12:0] i_clks,
  input wire logic i_clear,
  // Rising edges seen on each clock since the last clear.
  output int o_edges [13]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] prev_ff = '0;
  // A peripheral acts only on rising edges, so a runt pulse would show up as an extra edge.
  always @(i_clks or posedge i_clear)
  begin
    for (int k = 0; k < 13; k++)
    begin
      if (i_clear)
        o_edges[k] = 0;
      else if (i_clks[k] === 1'b1 && prev_ff[k] !== 1'b1)
        o_edges[k] = o_edges[k] + 1;
    end
    prev_ff = i_clks;
  end
endmodule // pcg_periph_model

//--- tb/peripheral_clock_gating_tb.sv
module peripheral_clock_gating_tb import pcg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] wd; logic [15:0] rd;} pcg_row_s;
  localparam logic [16:0] ad_g0 = 17'h1_C070;
  localparam logic [16:0] ad_g1 = 17'h1_C074;
  localparam logic [16:0] ad_ls = 17'h1_C06C;
  localparam logic [16:0] ad_pll = 17'h1_C084;
  localparam logic [16:0] ad_wdc = 17'h1_C08C;
  localparam logic [16:0] ad_none = 17'h1_C07C;
  localparam logic [16:0] ad_g3 = 17'h1_C080;
  localparam logic [16:0] ad_hs = 17'h1_C068;
  localparam pcg_row_s rows [6] = '{'{16'hFFFF, 16'hFD3C}, '{16'h02C3, 16'h0000},
    '{16'h8001, 16'h8000}, '{16'h4010, 16'h4010}, '{16'h2104, 16'h2104}, '{16'h0C28, 16'h0C28}};
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_soft_rst = 1'b0;
  logic ovr = 1'b1;
  logic clr = 1'b0;
  pcg_avs_req_s avs = '0;
  logic [31:0] rdata;
  logic wait_r, sys_clk, i2c_clk, lsp, hsp, tbs;
  logic [8:0] gated;
  logic [15:0] g1, g3;
  logic [15:0] scratch;
  int edges [13];
  int miscompares = 0;
  int checks = 0;

  pcg_clock_gate pcg_clock_gate_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_soft_rst(i_soft_rst),
    .i_write_protect_override(ovr), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .o_system_clock_out(sys_clk), .o_i2c_clock(i2c_clk),
    .o_gated_clock(gated), .o_low_speed_periph_clock(lsp), .o_high_speed_periph_clock(hsp),
    .o_timebase_sync(tbs), .o_gate1_en(g1), .o_gate3_en(g3));
  pcg_periph_model pcg_periph_model_i (.i_clks({hsp, lsp, i2c_clk, sys_clk, gated}), .i_clear(clr),
    .o_edges(edges));

  initial
  begin
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called just after a rising edge; returns one edge after the answer so that
  // back-to-back calls never assign the request twice in one time step.
  task automatic bus(logic is_wr, logic [16:0] a, logic [15:0] d, logic [3:0] be,
    output logic [15:0] q);
    avs.read <= !is_wr;
    avs.write <= is_wr;
    avs.address <= a;
    avs.writedata <= {16'h0000, d};
    avs.byteenable <= be;
    do @(posedge i_mclk); while (wait_r !== 1'b0);
    q = rdata[15:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic wr(logic [16:0] a, logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(string what, logic [16:0] a, logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, 4'hF, q);
    check(what, {16'h0000, exp}, {16'h0000, q});
  endtask

  task automatic count_chk(string what, int k, int lo, int hi);
    repeat (2) @(posedge i_mclk);
    clr = 1'b1;
    #1 clr = 1'b0;
    repeat (40) @(posedge i_mclk);
    #1;
    checks++;
    if (edges[k] < lo || edges[k] > hi)
    begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, edges[k]);
    end
    @(posedge i_mclk);
  endtask

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd_chk("gate0 reset", ad_g0, 16'h0000);
    #1 check("gated reset", 32'h0000_0000, {23'h00_0000, gated});
    @(posedge i_mclk);
    foreach (rows[i])
    begin
      wr(ad_g0, rows[i].wd);
      @(posedge i_mclk);
      #1 check("timebase sync", {31'h0000_0000, rows[i].rd[2]}, {31'h0000_0000, tbs});
      @(posedge i_mclk);
      rd_chk("gate0 readback", ad_g0, rows[i].rd);
    end
    wr(ad_g0, 16'h4118);
    count_chk("system clock edges", 9, 39, 41);
    count_chk("can a edges", 1, 19, 21);
    count_chk("can b edges", 0, 0, 0);
    count_chk("spi edges", 6, 19, 21);
    count_chk("i2c edges", 10, 39, 41);
    count_chk("uart a edges", 5, 0, 0);
    count_chk("converter edges", 8, 19, 21);
    wr(ad_ls, 16'h0001);
    count_chk("spi slow edges", 6, 9, 11);
    count_chk("low speed edges", 11, 9, 11);
    wr(ad_hs, 16'h0003);
    count_chk("converter slow edges", 8, 4, 6);
    count_chk("high speed edges", 12, 4, 6);
    ovr <= 1'b0;
    wr(ad_g1, 16'hFFFF);
    ovr <= 1'b1;
    rd_chk("gate1 protected", ad_g1, 16'h0000);
    wr(ad_g1, 16'hA5A5);
    #1 check("gate1 early", 32'h0000_0000, {16'h0000, g1});
    @(posedge i_mclk);
    #1 check("gate1 enables", 32'h0000_A5A5, {16'h0000, g1});
    @(posedge i_mclk);
    wr(ad_g3, 16'h0F0F);
    #1 check("gate3 early", 32'h0000_0000, {16'h0000, g3});
    @(posedge i_mclk);
    #1 check("gate3 enables", 32'h0000_0F0F, {16'h0000, g3});
    @(posedge i_mclk);
    wr(ad_pll, 16'h1234);
    i_soft_rst <= 1'b1;
    @(posedge i_mclk);
    i_soft_rst <= 1'b0;
    @(posedge i_mclk);
    rd_chk("pll kept", ad_pll, 16'h1234);
    rd_chk("gate1 soft", ad_g1, 16'h0000);
    bus(1'b1, ad_g1, 16'h5AFF, 4'h2, scratch);
    rd_chk("gate1 upper byte", ad_g1, 16'h5A00);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd_chk("pll hard", ad_pll, 16'h0000);
    rd_chk("unmapped", ad_none, 16'h0000);
    wr(ad_wdc, 16'hFFFF);
    rd_chk("wd counter", ad_wdc, 16'h0000);
    end_of_test();
  end
endmodule // peripheral_clock_gating_tb
